/* File: core/wdc_pkg.sv */
`default_nettype none

package wdc_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
        logic re;
    } wdc_bus_req_s;

    localparam logic [ADDR_W-1:0] OFS_CONTROL_STATUS_ONE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_STATUS_TWO = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_WATCHDOG_COUNT = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_WATCHDOG_CLOCK_CHOICE = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CS1_RESET_FLAG_POS = 0;
    localparam int CS1_RUN_POS = 1;
    localparam int CS1_RUN_GUARD_POS = 2;

    localparam int CS2_OVERFLOW_FLAG_POS = 7;
    localparam int CS2_MODE_GUARD_POS = 6;
    localparam int CS2_MODE_POS = 5;
    localparam int CS2_BIT3_GUARD_POS = 4;
    localparam int CS2_IRQ_ENABLE_POS = 3;

    localparam int IRQ_INTERVAL_POS = 0;
    localparam int IRQ_WATCHDOG_POS = 1;
    localparam int IRQ_BITS = 2;

    // ------------------------------------------------------------
    // Reset and read-back values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_MAX = 8'hFF;
    localparam logic [3:0] CLOCK_CODE_RESET = 4'h0;
    localparam logic [DATA_W-1:0] CLOCK_CHOICE_RSVD = 8'hF0;
    localparam logic [DATA_W-1:0] CS2_RSVD = 8'h07;
    localparam logic RUN_RESET = 1'b1;
    localparam logic MODE_RESET = 1'b0;
    localparam logic IRQ_ENABLE_RESET = 1'b0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int OSC_DIV_LOG2 = 11;
    localparam int WATCH_DIV_LOG2 = 8;
    localparam int SYS_DIV_LOG2 = 12;
    localparam int OSC_RESET_CYCLES = 512;
    localparam int HOLD_W = 10;

    typedef enum logic {
        WDC_MODE_WATCHDOG,
        WDC_MODE_INTERVAL
    } wdc_mode_e;

endpackage

`default_nettype wire

/* File: core/wdc_prescale.sv */
`timescale 1ns/1ps
`default_nettype none

// Free-running divider chain; bit n toggles every 2**n enabled steps.
module wdc_prescale #(
    parameter int WIDTH = 12
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic step_en,
    output logic [WIDTH-1:0] count
);

    logic [WIDTH-1:0] count_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_ff <= '0;
        end else if (step_en) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    assign count = count_ff;

endmodule // wdc_prescale

`default_nettype wire

/* File: core/wdc_top.sv */
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module wdc_top #(
    parameter int SYS_TOP_DIV_LOG2 = 13
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire wdc_pkg::wdc_bus_req_s bus_req,
    output logic [wdc_pkg::DATA_W-1:0] rdata,
    input wire logic onchip_osc_clock,
    input wire logic watch_clock,
    output logic internal_reset,
    output logic interval_irq,
    output logic irq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Divided tick: the enable is high and all lower chain bits are ones.
    function automatic logic div_tick(input logic [15:0] chain, input int log2, input logic en);
        logic [15:0] low_mask;
        low_mask = 16'hFFFF >> (16 - log2);
        div_tick = en && ((chain & low_mask) == low_mask);
    endfunction

    function automatic logic is_write(input wdc_pkg::wdc_bus_req_s req,
                                      input logic [wdc_pkg::ADDR_W-1:0] ofs);
        is_write = req.we && (req.addr == ofs);
    endfunction

    // Clear-only flag: hardware set wins over a software clear
    function automatic logic clear_only(input logic cur, input logic set,
                                        input logic wr, input logic wbit);
        clear_only = set || (cur && !(wr && !wbit));
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // A level counts only once stages two and three agree; this filters
    // a single-cycle glitch at the cost of one cycle of latency.
    logic [2:0] osc_sync_ff;
    logic [2:0] watch_sync_ff;
    logic osc_level_ff;
    logic watch_level_ff;
    logic osc_rise;
    logic watch_rise;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_sync_ff <= 3'h0;
            watch_sync_ff <= 3'h0;
        end else begin
            osc_sync_ff <= {osc_sync_ff[1:0], onchip_osc_clock};
            watch_sync_ff <= {watch_sync_ff[1:0], watch_clock};
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_level_ff <= 1'b0;
            watch_level_ff <= 1'b0;
        end else begin
            osc_level_ff <= (osc_sync_ff[1] == osc_sync_ff[2]) ? osc_sync_ff[2] : osc_level_ff;
            watch_level_ff <= (watch_sync_ff[1] == watch_sync_ff[2]) ? watch_sync_ff[2]
                : watch_level_ff;
        end
    end

    assign osc_rise = (osc_sync_ff[1] == osc_sync_ff[2]) && osc_sync_ff[2] && !osc_level_ff;
    assign watch_rise = (watch_sync_ff[1] == watch_sync_ff[2]) && watch_sync_ff[2]
        && !watch_level_ff;

    // ------------------------------------------------------------
    // Prescalers
    // ------------------------------------------------------------
    logic [15:0] osc_chain;
    logic [15:0] watch_chain;
    logic [15:0] sys_chain;

    wdc_prescale #(.WIDTH(16)) u_osc_div (
        .clock(clock), .arst_n(arst_n), .step_en(osc_rise), .count(osc_chain)
    );

    wdc_prescale #(.WIDTH(16)) u_watch_div (
        .clock(clock), .arst_n(arst_n), .step_en(watch_rise), .count(watch_chain)
    );

    wdc_prescale #(.WIDTH(16)) u_sys_div (
        .clock(clock), .arst_n(arst_n), .step_en(1'b1), .count(sys_chain)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] count_ff;
    logic [3:0] clock_code_ff;
    logic run_ff;
    logic reset_flag_ff;
    logic mode_ff;
    logic irq_enable_ff;
    logic overflow_flag_ff;
    logic [wdc_pkg::IRQ_BITS-1:0] irq_status_ff;
    logic [wdc_pkg::IRQ_BITS-1:0] irq_mask_ff;
    logic [wdc_pkg::DATA_W-1:0] rdata_ff;
    localparam int HOLD_W = wdc_pkg::HOLD_W;
    logic [wdc_pkg::HOLD_W-1:0] hold_cnt_ff;
    logic internal_reset_ff;
    logic interval_irq_ff;
    logic irq_ff;

    logic wr_cs1;
    logic wr_cs2;
    logic wr_count;
    logic wr_choice;
    logic [7:0] wd;

    assign wd = bus_req.wdata;
    assign wr_cs1 = is_write(bus_req, wdc_pkg::OFS_CONTROL_STATUS_ONE);
    assign wr_cs2 = is_write(bus_req, wdc_pkg::OFS_CONTROL_STATUS_TWO);
    assign wr_count = is_write(bus_req, wdc_pkg::OFS_WATCHDOG_COUNT);
    assign wr_choice = is_write(bus_req, wdc_pkg::OFS_WATCHDOG_CLOCK_CHOICE);

    // ------------------------------------------------------------
    // Clock source selection
    // ------------------------------------------------------------
    logic count_tick;

    always_comb begin
        count_tick = 1'b0;
        unique casez (clock_code_ff)
            4'b00??: count_tick = div_tick(osc_chain, wdc_pkg::OSC_DIV_LOG2, osc_rise);
            4'b0100: count_tick = div_tick(watch_chain, 4, watch_rise);
            4'b0101: count_tick = div_tick(watch_chain, wdc_pkg::WATCH_DIV_LOG2, watch_rise);
            4'b011?: count_tick = 1'b0;
            4'b1111: count_tick = div_tick(sys_chain, SYS_TOP_DIV_LOG2, 1'b1);
            // 1000 -> /64 ... 1110 -> /4096, one power of two per step
            default: count_tick = div_tick(sys_chain, 6 + int'(clock_code_ff[2:0]), 1'b1);
        endcase
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic overflow;

    // A bus write in the same cycle as a tick wins; the tick is lost,
    // which keeps the written start value exact.
    assign overflow = run_ff && count_tick && !wr_count && (count_ff == wdc_pkg::COUNT_MAX);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_ff <= wdc_pkg::COUNT_RESET;
        end else if (wr_count) begin
            count_ff <= wd;
        end else if (run_ff && count_tick) begin
            count_ff <= count_ff + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            clock_code_ff <= wdc_pkg::CLOCK_CODE_RESET;
        end else if (wr_choice) begin
            clock_code_ff <= wd[3:0];
        end
    end

    // ------------------------------------------------------------
    // Control and status one
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            run_ff <= wdc_pkg::RUN_RESET;
        end else if (wr_cs1 && !wd[wdc_pkg::CS1_RUN_GUARD_POS]) begin
            run_ff <= wd[wdc_pkg::CS1_RUN_POS];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reset_flag_ff <= 1'b0;
        end else begin
            reset_flag_ff <= clear_only(reset_flag_ff, overflow, wr_cs1,
                wd[wdc_pkg::CS1_RESET_FLAG_POS]);
        end
    end

    // ------------------------------------------------------------
    // Control and status two
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= wdc_pkg::MODE_RESET;
        end else if (wr_cs2 && !wd[wdc_pkg::CS2_MODE_GUARD_POS]) begin
            mode_ff <= wd[wdc_pkg::CS2_MODE_POS];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_enable_ff <= wdc_pkg::IRQ_ENABLE_RESET;
        end else if (wr_cs2 && !wd[wdc_pkg::CS2_BIT3_GUARD_POS]) begin
            irq_enable_ff <= wd[wdc_pkg::CS2_IRQ_ENABLE_POS];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            overflow_flag_ff <= 1'b0;
        end else begin
            overflow_flag_ff <= clear_only(overflow_flag_ff, overflow, wr_cs2,
                wd[wdc_pkg::CS2_OVERFLOW_FLAG_POS]);
        end
    end

    // ------------------------------------------------------------
    // Internal reset pulse
    // ------------------------------------------------------------
    // Held for a fixed number of oscillator edges, not system cycles, so
    // the width stays the same whatever clock the counter runs on.
    logic wd_overflow;

    assign wd_overflow = overflow && (mode_ff == wdc_pkg::WDC_MODE_WATCHDOG);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            internal_reset_ff <= 1'b0;
            hold_cnt_ff <= '0;
        end else if (wd_overflow) begin
            internal_reset_ff <= 1'b1;
            hold_cnt_ff <= HOLD_W'(wdc_pkg::OSC_RESET_CYCLES);
        end else if (internal_reset_ff && osc_rise) begin
            hold_cnt_ff <= hold_cnt_ff - 1'b1;
            if (hold_cnt_ff == HOLD_W'(1)) begin
                internal_reset_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Interval interrupt request
    // ------------------------------------------------------------
    // Request follows the flag while in interval mode with the enable set, so it stays up until software clears the flag or the enable.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            interval_irq_ff <= 1'b0;
        end else begin
            interval_irq_ff <= (mode_ff == wdc_pkg::WDC_MODE_INTERVAL) && irq_enable_ff
                && clear_only(overflow_flag_ff, overflow, wr_cs2,
                    wd[wdc_pkg::CS2_OVERFLOW_FLAG_POS]);
        end
    end

    // ------------------------------------------------------------
    // Event status, mask and interrupt line
    // ------------------------------------------------------------
    logic [wdc_pkg::IRQ_BITS-1:0] irq_events;
    logic [wdc_pkg::IRQ_BITS-1:0] irq_clear;
    logic [wdc_pkg::IRQ_BITS-1:0] nxt_irq_status;

    always_comb begin
        irq_events = '0;
        irq_events[wdc_pkg::IRQ_INTERVAL_POS] = overflow && (mode_ff == wdc_pkg::WDC_MODE_INTERVAL);
        irq_events[wdc_pkg::IRQ_WATCHDOG_POS] = wd_overflow;
    end

    assign irq_clear = is_write(bus_req, wdc_pkg::OFS_IRQ_STATUS) ?
        wd[wdc_pkg::IRQ_BITS-1:0] : '0;
    assign nxt_irq_status = irq_events | (irq_status_ff & ~irq_clear);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_status_ff <= '0;
        end else begin
            irq_status_ff <= nxt_irq_status;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_ff <= '0;
        end else if (is_write(bus_req, wdc_pkg::OFS_IRQ_MASK)) begin
            irq_mask_ff <= wd[wdc_pkg::IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_irq_status & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        unique case (bus_req.addr)
            wdc_pkg::OFS_CONTROL_STATUS_ONE: begin
                rd_mux[wdc_pkg::CS1_RESET_FLAG_POS] = reset_flag_ff;
                rd_mux[wdc_pkg::CS1_RUN_POS] = run_ff;
                rd_mux[wdc_pkg::CS1_RUN_GUARD_POS] = 1'b1;
            end
            wdc_pkg::OFS_CONTROL_STATUS_TWO: begin
                rd_mux = wdc_pkg::CS2_RSVD;
                rd_mux[wdc_pkg::CS2_OVERFLOW_FLAG_POS] = overflow_flag_ff;
                rd_mux[wdc_pkg::CS2_MODE_GUARD_POS] = 1'b1;
                rd_mux[wdc_pkg::CS2_MODE_POS] = mode_ff;
                rd_mux[wdc_pkg::CS2_BIT3_GUARD_POS] = 1'b1;
                rd_mux[wdc_pkg::CS2_IRQ_ENABLE_POS] = irq_enable_ff;
            end
            wdc_pkg::OFS_WATCHDOG_COUNT: rd_mux = count_ff;
            wdc_pkg::OFS_WATCHDOG_CLOCK_CHOICE: rd_mux = wdc_pkg::CLOCK_CHOICE_RSVD
                | {4'h0, clock_code_ff};
            wdc_pkg::OFS_IRQ_STATUS: rd_mux = {6'h00, irq_status_ff};
            wdc_pkg::OFS_IRQ_MASK: rd_mux = {6'h00, irq_mask_ff};
            default: rd_mux = 8'h00;
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= bus_req.re ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata = rdata_ff;
    assign internal_reset = internal_reset_ff;
    assign interval_irq = interval_irq_ff;
    assign irq = irq_ff;

endmodule // wdc_top

`default_nettype wire

/* File: tb/wdc_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module wdc_monitor #(
    parameter int SYS_TOP_DIV_LOG2 = 13
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire wdc_pkg::wdc_bus_req_s bus_req,
    input wire logic [wdc_pkg::DATA_W-1:0] rdata,
    input wire logic onchip_osc_clock,
    input wire logic watch_clock,
    input wire logic internal_reset,
    input wire logic interval_irq,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Oscillator edges counted while internal reset holds
    // ------------------------------------------------------------
    // Raw pin is sampled here; the sync delay only shifts the window by one edge
    logic osc_ff;
    logic [10:0] osc_cnt_ff;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_ff <= 1'b0;
            osc_cnt_ff <= 11'h000;
        end else begin
            osc_ff <= onchip_osc_clock;
            if (!internal_reset) begin
                osc_cnt_ff <= 11'h000;
            end else if (onchip_osc_clock && !osc_ff) begin
                osc_cnt_ff <= osc_cnt_ff + 11'h001;
            end
        end
    end

    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    rdata_idle_a: assert property (!$past(bus_req.re) |-> rdata == 8'h00)
        else $error("read data not idle");
    choice_rsvd_a: assert property (bus_req.re && bus_req.addr == 4'h3 |=> rdata[7:4] == 4'hF)
        else $error("clock choice upper bits not ones");
    cs2_fixed_a: assert property (bus_req.re && bus_req.addr == 4'h1 |=>
        rdata[2:0] == 3'h7 && rdata[6] && rdata[4]) else $error("status two fixed bits wrong");
    cs1_guard_a: assert property (bus_req.re && bus_req.addr == 4'h0 |=> rdata[2])
        else $error("run guard not read as one");
    count_rw_a: assert property ((bus_req.we && bus_req.addr == 4'h2) ##2
        (bus_req.re && bus_req.addr == 4'h2) |=> rdata inside {$past(bus_req.wdata, 3),
        $past(bus_req.wdata, 3) + 8'h01}) else $error("count not taken from write");
    choice_rw_a: assert property ((bus_req.we && bus_req.addr == 4'h3) ##2
        (bus_req.re && bus_req.addr == 4'h3) |=> rdata[3:0] == $past(bus_req.wdata[3:0], 3))
        else $error("clock code not stored");
    irq_excl_a: assert property ($rose(internal_reset) |-> !interval_irq)
        else $error("reset and interval request together");
    wd_reset_len_a: assert property ($fell(internal_reset) |-> osc_cnt_ff inside {[510:513]})
        else $error("internal reset length wrong");
    irq_off_a: assert property (bus_req.we && bus_req.addr == 4'h1 && !bus_req.wdata[7]
        |-> ##2 !interval_irq) else $error("interval request not withdrawn");
endmodule // wdc_monitor

bind wdc_top wdc_monitor #(.SYS_TOP_DIV_LOG2(SYS_TOP_DIV_LOG2)) wdc_monitor_inst (
    .clock(clock), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
    .onchip_osc_clock(onchip_osc_clock), .watch_clock(watch_clock),
    .internal_reset(internal_reset), .interval_irq(interval_irq), .irq(irq));

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // Short divider for code 1111 keeps the run brief
    localparam int TOP_LOG2 = 7;
    localparam logic [3:0] CS1 = wdc_pkg::OFS_CONTROL_STATUS_ONE;
    localparam logic [3:0] CS2 = wdc_pkg::OFS_CONTROL_STATUS_TWO;
    localparam logic [3:0] CNT = wdc_pkg::OFS_WATCHDOG_COUNT;
    localparam logic [3:0] CHO = wdc_pkg::OFS_WATCHDOG_CLOCK_CHOICE;
    localparam logic [3:0] IST = wdc_pkg::OFS_IRQ_STATUS;
    localparam logic [3:0] IMK = wdc_pkg::OFS_IRQ_MASK;
    logic clock;
    logic arst_n;
    logic onchip_osc_clock;
    logic watch_clock;
    wdc_pkg::wdc_bus_req_s bus_req;
    logic [7:0] rdata;
    logic internal_reset;
    logic interval_irq;
    logic irq;
    logic [7:0] rd_val;
    int failures;
    int cmp_count;
    int t0;
    int i;

    wdc_top #(.SYS_TOP_DIV_LOG2(TOP_LOG2)) wdc_top_inst (.clock(clock), .arst_n(arst_n),
        .bus_req(bus_req), .rdata(rdata), .onchip_osc_clock(onchip_osc_clock),
        .watch_clock(watch_clock), .internal_reset(internal_reset),
        .interval_irq(interval_irq), .irq(irq));

    // ------------------------------------------------------------
    // Clocks; pins toggle on odd ns so they never meet a clock edge
    // ------------------------------------------------------------
    always #2 clock = ~clock;
    initial begin
        #1;
        forever #10 onchip_osc_clock = ~onchip_osc_clock;
    end
    initial begin
        #1;
        forever #12 watch_clock = ~watch_clock;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] lo, input logic [15:0] hi);
        cmp_count++;
        if (((seen >= lo) && (seen <= hi)) !== 1'b1) begin
            failures++;
            $display("wrong value at %0t: saw %h, wanted %h to %h", $time, seen, lo, hi);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1;
        rd_val = rdata;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        rd(a);
        chk(rd_val, e, e);
    endtask
    task automatic rate(input logic [3:0] c, input int n);
        wr(CHO, {4'h0, c});
        wr(CNT, 8'h00);
        repeat (n) @(posedge clock);
        rd(CNT);
    endtask
    task automatic wait_for(input logic sel, input logic v, input int lim);
        t0 = 0;
        while ((sel ? interval_irq : internal_reset) !== v && t0 < lim) begin
            @(posedge clock);
            #1;
            t0++;
        end
    endtask
    task automatic summarize;
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        failures++;
        summarize;
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        bus_req = '0;
        onchip_osc_clock = 1'b0;
        watch_clock = 1'b0;
        failures = 0;
        cmp_count = 0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        rdc(CS1, 8'h06);
        rdc(CS2, 8'h57);
        rdc(CNT, 8'h00);
        rdc(CHO, 8'hF0);
        rdc(IST, 8'h00);
        rdc(IMK, 8'h00);
        wr(4'h7, 8'hFF);
        rdc(4'h7, 8'h00);
        wr(CS2, 8'h58);
        rdc(CS2, 8'h57);
        wr(CS2, 8'h08);
        rdc(CS2, 8'h5F);
        wr(CS2, 8'h50);
        rdc(CS2, 8'h5F);
        for (i = 0; i < 16; i++) begin
            wr(CHO, {4'hA, 4'(i)});
            rdc(CHO, {4'hF, 4'(i)});
        end
        wr(CNT, 8'hA5);
        rd(CNT);
        chk(rd_val, 8'hA5, 8'hA6);
        for (i = 8; i < 16; i++) begin
            rate(4'(i), 4 << ((i == 15) ? TOP_LOG2 : i - 2));
            chk(rd_val, 3, 5);
        end
        rate(4'h4, 384);
        chk(rd_val, 3, 5);
        rate(4'h5, 6144);
        chk(rd_val, 3, 5);
        rate(4'h6, 400);
        chk(rd_val, 0, 0);
        rate(4'h7, 400);
        chk(rd_val, 0, 0);
        wr(CHO, 8'h03);
        wr(CNT, 8'hFE);
        wait_for(1'b0, 1'b1, 25000);
        chk(t0, 10230, 20500);
        wait_for(1'b0, 1'b0, 3000);
        chk(t0, 2550, 2570);
        rdc(CS1, 8'h07);
        rdc(CS2, 8'hDF);
        rdc(IST, 8'h02);
        wr(IMK, 8'h02);
        @(posedge clock);
        #1;
        chk(irq, 1, 1);
        wr(IST, 8'h02);
        @(posedge clock);
        #1;
        chk(irq, 0, 0);
        wr(CS1, 8'h05);
        rdc(CS1, 8'h07);
        wr(CS1, 8'h04);
        rdc(CS1, 8'h06);
        wr(CS2, 8'hD0);
        rdc(CS2, 8'hDF);
        wr(CS2, 8'h50);
        rdc(CS2, 8'h5F);
        wr(CS2, 8'h30);
        rdc(CS2, 8'h7F);
        wr(CHO, 8'h08);
        wr(CNT, 8'hFF);
        wait_for(1'b1, 1'b1, 200);
        chk(interval_irq, 1, 1);
        chk(internal_reset, 0, 0);
        rdc(IST, 8'h01);
        rdc(CS2, 8'hFF);
        wr(CS2, 8'h60);
        rdc(CS2, 8'h77);
        chk(interval_irq, 0, 0);
        wr(CNT, 8'hFF);
        repeat (200) @(posedge clock);
        #1;
        chk(interval_irq, 0, 0);
        rdc(CS2, 8'hF7);
        summarize;
    end
endmodule // tb_top

`default_nettype wire
